// [hw/cpmc_key_guard.sv]
// Key sequence guard for one protected control register
`timescale 1ns/1ps
`default_nettype none

module cpmc_key_guard #(
    parameter logic [15:0] KEY_FIRST = 16'h0000,
    parameter logic [15:0] KEY_SECOND = 16'h0000
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Taken bus write and its target
    input wire logic wr_taken,
    input wire logic hit_first,
    input wire logic hit_ctrl,
    input wire logic hit_second,
    input wire logic [15:0] wdata,
    // Committed value
    output logic commit,
    output logic [7:0] commit_data
);

    cpmc_pkg::cpmc_guard_t st;
    cpmc_pkg::cpmc_guard_t next_st;
    logic first_ok;

    assign first_ok = hit_first && (wdata == KEY_FIRST);

    always_comb begin
        next_st = st;
        next_st.commit = 1'b0;
        if (wr_taken) begin
            case (st.state)
                cpmc_pkg::CPMC_G_ARMED: begin
                    if (hit_ctrl) begin
                        next_st.state = cpmc_pkg::CPMC_G_STAGED;
                        next_st.data = wdata[7:0];
                    end else begin
                        next_st.state = first_ok ? cpmc_pkg::CPMC_G_ARMED : cpmc_pkg::CPMC_G_IDLE;
                    end
                end
                cpmc_pkg::CPMC_G_STAGED: begin
                    if (hit_second && (wdata == KEY_SECOND)) begin
                        next_st.commit = 1'b1;
                        next_st.state = cpmc_pkg::CPMC_G_IDLE;
                    end else begin
                        next_st.state = first_ok ? cpmc_pkg::CPMC_G_ARMED : cpmc_pkg::CPMC_G_IDLE;
                    end
                end
                default: begin
                    next_st.state = first_ok ? cpmc_pkg::CPMC_G_ARMED : cpmc_pkg::CPMC_G_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '{state: cpmc_pkg::CPMC_G_IDLE, data: 8'h00, commit: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign commit = st.commit;
    assign commit_data = st.data;

    sequence s_staged_key2;
        st.state == cpmc_pkg::CPMC_G_STAGED && wr_taken && hit_second && wdata == KEY_SECOND;
    endsequence

    // Key, control and second key as three writes, each two idle cycles apart
    sequence s_full_unlock;
        (wr_taken && first_ok) ##1 (!wr_taken)[*2] ##1 (wr_taken && hit_ctrl)
            ##1 (!wr_taken)[*2] ##1 (wr_taken && hit_second && wdata == KEY_SECOND);
    endsequence

    a_key2_commits: assert property (@(posedge pclk) disable iff (!presetn)
        s_staged_key2 |=> commit && commit_data == $past(st.data))
        else $error("Second key after staged write did not commit");
    a_commit_cause: assert property (@(posedge pclk) disable iff (!presetn)
        commit |-> $past(st.state == cpmc_pkg::CPMC_G_STAGED && wr_taken && hit_second))
        else $error("Commit without staged write and second key");
    a_sequence_commits: assert property (@(posedge pclk) disable iff (!presetn)
        s_full_unlock |=> commit)
        else $error("Full key sequence did not commit");
    a_stray_drops: assert property (@(posedge pclk) disable iff (!presetn)
        (st.state == cpmc_pkg::CPMC_G_STAGED && wr_taken && !hit_second && !first_ok)
        |=> !commit && st.state == cpmc_pkg::CPMC_G_IDLE)
        else $error("Stray write did not cancel the key sequence");

endmodule

`default_nettype wire

// [hw/cpmc_top.sv]
// Clock source and power mode control with key-protected APB registers
// How it works
// - Reference select bit 5 set picks internal oscillator; it resets to one.
// - Reference select cleared takes loop reference from the external crystal.
// - Clock mode 01 picks the loop clock, 11 the external clock pin.
// - Operating mode 6:4 picks active..stop; sleep wakes only on ext irq 0-3 or timer.
// - Divider 2:0 slows the core clock by two to the power of its value.
// - Loop multiplies its reference by 1275 to make the system clock.
// - A new clock source takes effect only while the part naps.
// - Loss of lock in loop clock mode 01 halts the core clock and raises a loop interrupt later.
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "cpmc_defines.svh"

module cpmc_top (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Asynchronous pins: loop lock, external interrupts 0..3, wake timer
    input wire logic loop_lock_pin,
    input wire logic [3:0] external_interrupt,
    input wire logic wake_timer,
    // Same-clock interrupt controller signals
    input wire logic other_irq,
    input wire logic loop_irq_ack,
    // Clock selection
    output logic loop_reference_select,
    output logic [1:0] clock_source_mode,
    output logic [10:0] loop_multiplier,
    output logic [2:0] operating_mode_field,
    output logic [2:0] core_clock_divider,
    output logic core_clock_enable,
    // Power domains and loop interrupt
    output logic core_powered,
    output logic peripherals_powered,
    output logic loop_powered,
    output logic timers_powered,
    output logic loop_irq
);

    // ==============================================
    // State
    typedef struct packed {
        logic loop_ref;
        logic [1:0] loop_mode;
        cpmc_pkg::cpmc_op_mode_t op_mode;
        logic [2:0] cdiv;
        logic act_ref;
        logic [1:0] act_mode;
        logic [5:0] sync1;
        logic [5:0] sync2;
        logic lock_d;
        logic irq_pend;
        logic irq_out;
        logic [6:0] div_cnt;
        logic core_en;
        logic [3:0] pwr;
        logic [31:0] rdata;
    } cpmc_state_t;

    cpmc_state_t st;
    cpmc_state_t next_st;

    // ==============================================
    // Bus decode
    logic wr_taken;
    logic rd_setup;
    logic hit_pk1;
    logic hit_pctl;
    logic hit_pk2;
    logic hit_lk1;
    logic hit_lctl;
    logic hit_lk2;
    logic hit_stat;
    logic mapped;
    logic loop_commit;
    logic power_commit;
    logic [7:0] loop_data;
    logic [7:0] power_data;

    assign wr_taken = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign hit_pk1 = (paddr == `CPMC_ADDR_POWER_KEY_FIRST);
    assign hit_pctl = (paddr == `CPMC_ADDR_POWER_MODE_CONTROL);
    assign hit_pk2 = (paddr == `CPMC_ADDR_POWER_KEY_SECOND);
    assign hit_lk1 = (paddr == `CPMC_ADDR_LOOP_KEY_FIRST);
    assign hit_lctl = (paddr == `CPMC_ADDR_LOOP_CLOCK_CONTROL);
    assign hit_lk2 = (paddr == `CPMC_ADDR_LOOP_KEY_SECOND);
    assign hit_stat = (paddr == `CPMC_ADDR_STATUS);
    assign mapped = hit_pk1 | hit_pctl | hit_pk2 | hit_lk1 | hit_lctl | hit_lk2 | hit_stat;

    // Zero wait states; unmapped access answers with an error
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // ==============================================
    // Key guards
    cpmc_key_guard #(
        .KEY_FIRST(`CPMC_LOOP_KEY_FIRST_VAL),
        .KEY_SECOND(`CPMC_LOOP_KEY_SECOND_VAL)
    ) u_loop_guard (
        .pclk(pclk),
        .presetn(presetn),
        .wr_taken(wr_taken),
        .hit_first(hit_lk1),
        .hit_ctrl(hit_lctl),
        .hit_second(hit_lk2),
        .wdata(pwdata[15:0]),
        .commit(loop_commit),
        .commit_data(loop_data)
    );

    cpmc_key_guard #(
        .KEY_FIRST(`CPMC_POWER_KEY_FIRST_VAL),
        .KEY_SECOND(`CPMC_POWER_KEY_SECOND_VAL)
    ) u_power_guard (
        .pclk(pclk),
        .presetn(presetn),
        .wr_taken(wr_taken),
        .hit_first(hit_pk1),
        .hit_ctrl(hit_pctl),
        .hit_second(hit_pk2),
        .wdata(pwdata[15:0]),
        .commit(power_commit),
        .commit_data(power_data)
    );

    // ==============================================
    // Synchronised pin levels
    logic locked;
    logic [3:0] ext_s;
    logic timer_s;
    logic wake;
    logic core_run;
    logic [6:0] div_mask;
    logic tick;

    assign locked = st.sync2[5];
    assign ext_s = st.sync2[3:0];
    assign timer_s = st.sync2[4];

    // Wake sources per low-power mode
    always_comb begin
        case (st.op_mode)
            cpmc_pkg::CPMC_OP_PAUSE: wake = (|ext_s) || timer_s || other_irq;
            cpmc_pkg::CPMC_OP_NAP: wake = (|ext_s) || timer_s || other_irq;
            cpmc_pkg::CPMC_OP_SLEEP: wake = (|ext_s) || timer_s;
            cpmc_pkg::CPMC_OP_STOP: wake = |ext_s;
            default: wake = 1'b0;
        endcase
    end

    // Core runs only when active and its source is good
    assign core_run = (st.op_mode == cpmc_pkg::CPMC_OP_ACTIVE)
        && ((st.act_mode == `CPMC_CLK_MODE_EXT) || locked);

    assign div_mask = 7'((8'h01 << st.cdiv) - 8'h01);
    assign tick = ((st.div_cnt & div_mask) == div_mask);

    // ==============================================
    // Next state
    always_comb begin
        next_st = st;
        next_st.sync1 = {loop_lock_pin, wake_timer, external_interrupt};
        next_st.sync2 = st.sync1;
        next_st.lock_d = locked;
        next_st.div_cnt = 7'(st.div_cnt + 7'h01);
        if (loop_commit) begin
            next_st.loop_ref = loop_data[`CPMC_REF_SEL_BIT];
            next_st.loop_mode = loop_data[`CPMC_CLK_MODE_MSB:0];
        end
        if (power_commit) begin
            next_st.op_mode = cpmc_pkg::cpmc_op_mode_t'(power_data[`CPMC_OP_MODE_MSB:`CPMC_OP_MODE_LSB]);
            next_st.cdiv = power_data[`CPMC_CDIV_MSB:0];
        end else if (wake) begin
            next_st.op_mode = cpmc_pkg::CPMC_OP_ACTIVE;
        end
        if (st.op_mode == cpmc_pkg::CPMC_OP_NAP) begin
            next_st.act_ref = st.loop_ref;
            next_st.act_mode = st.loop_mode;
        end
        if (loop_irq_ack) begin
            next_st.irq_pend = 1'b0;
        end
        if (st.lock_d && !locked && st.act_mode == `CPMC_CLK_MODE_LOOP) begin
            next_st.irq_pend = 1'b1;
        end
        next_st.irq_out = next_st.irq_pend && locked;
        next_st.core_en = core_run && tick;
        case (next_st.op_mode)
            cpmc_pkg::CPMC_OP_PAUSE: next_st.pwr = 4'h7;
            cpmc_pkg::CPMC_OP_NAP: next_st.pwr = 4'h3;
            cpmc_pkg::CPMC_OP_SLEEP: next_st.pwr = 4'h1;
            cpmc_pkg::CPMC_OP_STOP: next_st.pwr = 4'h0;
            default: next_st.pwr = 4'hF;
        endcase
        if (rd_setup) begin
            next_st.rdata = 32'h00000000;
            if (hit_pctl) begin
                next_st.rdata[7:0] = {1'b0, st.op_mode, 1'b0, st.cdiv};
            end
            if (hit_lctl) begin
                next_st.rdata[7:0] = {2'h0, st.loop_ref, 3'h0, st.loop_mode};
            end
            if (hit_stat) begin
                next_st.rdata[7:0] = {2'h0, st.irq_pend, core_run, st.act_mode, st.act_ref, locked};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '{
                loop_ref: 1'b1,
                loop_mode: `CPMC_CLK_MODE_LOOP,
                op_mode: cpmc_pkg::CPMC_OP_ACTIVE,
                cdiv: 3'h3,
                act_ref: 1'b1,
                act_mode: `CPMC_CLK_MODE_LOOP,
                sync1: 6'h00,
                sync2: 6'h00,
                lock_d: 1'b0,
                irq_pend: 1'b0,
                irq_out: 1'b0,
                div_cnt: 7'h00,
                core_en: 1'b0,
                pwr: 4'hF,
                rdata: 32'h00000000
            };
        end else begin
            st <= next_st;
        end
    end

    // ==============================================
    // Outputs
    assign prdata = st.rdata;
    assign loop_reference_select = st.act_ref;
    assign clock_source_mode = st.act_mode;
    assign loop_multiplier = `CPMC_LOOP_MULT;
    assign operating_mode_field = st.op_mode;
    assign core_clock_divider = st.cdiv;
    assign core_clock_enable = st.core_en;
    assign core_powered = st.pwr[3];
    assign peripherals_powered = st.pwr[2];
    assign loop_powered = st.pwr[1];
    assign timers_powered = st.pwr[0];
    assign loop_irq = st.irq_out;

    // ==============================================
    // Checks
    a_unlock_halts: assert property (@(posedge pclk) disable iff (!presetn)
        (st.act_mode == `CPMC_CLK_MODE_LOOP && !locked) |=> !core_clock_enable)
        else $error("Core clock ran while loop unlocked");
    a_loss_raises: assert property (@(posedge pclk) disable iff (!presetn)
        (st.lock_d && !locked && st.act_mode == `CPMC_CLK_MODE_LOOP) |=> st.irq_pend)
        else $error("Lock loss did not set loop interrupt");
    a_irq_waits_lock: assert property (@(posedge pclk) disable iff (!presetn)
        !locked |=> !loop_irq)
        else $error("Loop interrupt raised while unlocked");
    a_nap_applies: assert property (@(posedge pclk) disable iff (!presetn)
        (st.op_mode == cpmc_pkg::CPMC_OP_NAP) |=> st.act_ref == $past(st.loop_ref)
            && st.act_mode == $past(st.loop_mode))
        else $error("Source not applied in nap");
    a_source_held: assert property (@(posedge pclk) disable iff (!presetn)
        (st.op_mode != cpmc_pkg::CPMC_OP_NAP) |=> $stable(st.act_ref) && $stable(st.act_mode))
        else $error("Source changed outside nap");
    a_div_full: assert property (@(posedge pclk) disable iff (!presetn)
        (core_run && st.cdiv == 3'h0) |=> core_clock_enable)
        else $error("Undivided core clock missed a cycle");
    a_div_half: assert property (@(posedge pclk) disable iff (!presetn)
        (core_clock_enable && st.cdiv == 3'h1 && $stable(st.cdiv)) |=> !core_clock_enable)
        else $error("Divide by two gave back to back enables");
    a_sleep_stays: assert property (@(posedge pclk) disable iff (!presetn)
        (st.op_mode == cpmc_pkg::CPMC_OP_SLEEP && !power_commit && !(|ext_s) && !timer_s)
        |=> st.op_mode == cpmc_pkg::CPMC_OP_SLEEP)
        else $error("Sleep left without a permitted wake source");
    a_ext_ignores_lock: assert property (@(posedge pclk) disable iff (!presetn)
        (st.act_mode == `CPMC_CLK_MODE_EXT) |-> core_run == (st.op_mode == cpmc_pkg::CPMC_OP_ACTIVE))
        else $error("External clock mode gated by lock");
    a_loop_commit: assert property (@(posedge pclk) disable iff (!presetn)
        loop_commit |=> st.loop_ref == $past(loop_data[5]) && st.loop_mode == $past(loop_data[1:0]))
        else $error("Committed loop value not stored");

endmodule

`default_nettype wire

// [include/cpmc_defines.svh]
// Address map, key values, reset values and field positions of the clock/power control block
`ifndef CPMC_DEFINES_SVH
`define CPMC_DEFINES_SVH

// ==============================================
// Register byte addresses
`define CPMC_ADDR_POWER_KEY_FIRST 32'hFFFF0404
`define CPMC_ADDR_POWER_MODE_CONTROL 32'hFFFF0408
`define CPMC_ADDR_POWER_KEY_SECOND 32'hFFFF040C
`define CPMC_ADDR_LOOP_KEY_FIRST 32'hFFFF0410
`define CPMC_ADDR_LOOP_CLOCK_CONTROL 32'hFFFF0414
`define CPMC_ADDR_LOOP_KEY_SECOND 32'hFFFF0418
`define CPMC_ADDR_STATUS 32'hFFFF0420

// ==============================================
// Key values
`define CPMC_LOOP_KEY_FIRST_VAL 16'h00AA
`define CPMC_LOOP_KEY_SECOND_VAL 16'h0055
`define CPMC_POWER_KEY_FIRST_VAL 16'h0001
`define CPMC_POWER_KEY_SECOND_VAL 16'h00F4

// ==============================================
// Reset values and fields
`define CPMC_LOOP_CTRL_RESET 8'h21
`define CPMC_POWER_CTRL_RESET 8'h03
`define CPMC_REF_SEL_BIT 5
`define CPMC_CLK_MODE_MSB 1
`define CPMC_OP_MODE_MSB 6
`define CPMC_OP_MODE_LSB 4
`define CPMC_CDIV_MSB 2
`define CPMC_CLK_MODE_LOOP 2'h1
`define CPMC_CLK_MODE_EXT 2'h3
`define CPMC_LOOP_MULT 11'h4FB

`endif

// [include/cpmc_pkg.sv]
// Types shared by the clock/power control block
package cpmc_pkg;

    typedef enum logic [2:0] {
        CPMC_OP_ACTIVE = 3'h0,
        CPMC_OP_PAUSE = 3'h1,
        CPMC_OP_NAP = 3'h2,
        CPMC_OP_SLEEP = 3'h3,
        CPMC_OP_STOP = 3'h4
    } cpmc_op_mode_t;

    typedef enum logic [2:0] {
        CPMC_G_IDLE = 3'h1,
        CPMC_G_ARMED = 3'h2,
        CPMC_G_STAGED = 3'h4
    } cpmc_guard_state_t;

    typedef struct packed {
        cpmc_guard_state_t state;
        logic [7:0] data;
        logic commit;
    } cpmc_guard_t;

endpackage

// [sim/tb_clock_power_mode_control.sv]
// Self-checking testbench of the clock source and power mode control block
`timescale 1ns/1ps
`default_nettype none
`include "cpmc_defines.svh"

module tb_clock_power_mode_control;

    // ==============================================
    // Signals
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h00000000;
    logic [31:0] pwdata = 32'h00000000;
    logic loop_lock_pin = 1'b1;
    logic [3:0] external_interrupt = 4'h0;
    logic wake_timer = 1'b0;
    logic other_irq = 1'b0;
    logic loop_irq_ack = 1'b0;
    logic pready, pslverr, loop_reference_select, core_clock_enable, loop_irq;
    logic core_powered, peripherals_powered, loop_powered, timers_powered;
    logic [31:0] prdata;
    logic [1:0] clock_source_mode;
    logic [10:0] loop_multiplier;
    logic [2:0] operating_mode_field, core_clock_divider;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    localparam int LIMIT = 8000;
    localparam logic [31:0] UNMAPPED = 32'hFFFF0430;

    cpmc_top dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .loop_lock_pin(loop_lock_pin), .external_interrupt(external_interrupt),
        .wake_timer(wake_timer), .other_irq(other_irq), .loop_irq_ack(loop_irq_ack),
        .loop_reference_select(loop_reference_select), .clock_source_mode(clock_source_mode),
        .loop_multiplier(loop_multiplier), .operating_mode_field(operating_mode_field),
        .core_clock_divider(core_clock_divider), .core_clock_enable(core_clock_enable),
        .core_powered(core_powered), .peripherals_powered(peripherals_powered),
        .loop_powered(loop_powered), .timers_powered(timers_powered), .loop_irq(loop_irq)
    );

    always #12.5 pclk = ~pclk;

    // ==============================================
    // Closing and timeout
    task automatic wrap_up();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            failures = failures + 1;
            $display("CHECK FAILED at %0t: run did not finish in time", $time);
            wrap_up();
        end
    end

    // ==============================================
    // Compare tasks
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic check_flag(input logic got, input logic exp, input string what);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    // ==============================================
    // Bus and helper tasks
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h00000000, r, e);
        check_val(r, exp, "read data");
        check_flag(e, exp_err, "slave error");
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic key_write(input logic lp, input logic [7:0] v);
        if (lp) begin
            wr(`CPMC_ADDR_LOOP_KEY_FIRST, 32'h000000AA);
            wr(`CPMC_ADDR_LOOP_CLOCK_CONTROL, {24'h000000, v});
            wr(`CPMC_ADDR_LOOP_KEY_SECOND, 32'h00000055);
        end else begin
            wr(`CPMC_ADDR_POWER_KEY_FIRST, 32'h00000001);
            wr(`CPMC_ADDR_POWER_MODE_CONTROL, {24'h000000, v});
            wr(`CPMC_ADDR_POWER_KEY_SECOND, 32'h000000F4);
        end
        wait_cyc(3);
    endtask

    task automatic seq3(input logic [31:0] a1, d1, a2, d2, a3, d3);
        wr(a1, d1);
        wr(a2, d2);
        wr(a3, d3);
        wait_cyc(3);
        rd_chk(`CPMC_ADDR_POWER_MODE_CONTROL, 32'h00000003, 1'b0);
    endtask

    task automatic set_src(input int s, input logic v);
        case (s)
            0: other_irq <= v;
            1: wake_timer <= v;
            default: external_interrupt[3] <= v;
        endcase
    endtask

    // ==============================================
    // Scenarios
    task automatic test_reset();
        check_flag(loop_reference_select, 1'b1, "reference after reset");
        check_val({30'h0, clock_source_mode}, 32'h00000001, "clock mode after reset");
        check_val({21'h0, loop_multiplier}, 32'h000004FB, "loop multiplier");
        rd_chk(`CPMC_ADDR_LOOP_CLOCK_CONTROL, 32'h00000021, 1'b0);
        rd_chk(`CPMC_ADDR_POWER_MODE_CONTROL, 32'h00000003, 1'b0);
        rd_chk(`CPMC_ADDR_POWER_KEY_FIRST, 32'h00000000, 1'b0);
        rd_chk(`CPMC_ADDR_STATUS, 32'h00000017, 1'b0);
        rd_chk(UNMAPPED, 32'h00000000, 1'b1);
        $display("test reset done");
    endtask

    task automatic test_divider();
        int cnt;
        for (int k = 0; k < 8; k++) begin
            key_write(1'b0, {5'h00, 3'(k)});
            rd_chk(`CPMC_ADDR_POWER_MODE_CONTROL, {29'h0, 3'(k)}, 1'b0);
            check_val({29'h0, core_clock_divider}, {29'h0, 3'(k)}, "divider code");
            cnt = 0;
            repeat (256) begin
                @(posedge pclk);
                if (core_clock_enable === 1'b1) cnt++;
            end
            check_val(32'(cnt), 32'(256 >> k), "core clock pulses in 256 cycles");
        end
        key_write(1'b0, 8'h03);
        $display("test divider done");
    endtask

    task automatic test_bad_keys();
        seq3(`CPMC_ADDR_POWER_KEY_FIRST, 32'h1, `CPMC_ADDR_POWER_KEY_SECOND, 32'hF4,
             `CPMC_ADDR_POWER_MODE_CONTROL, 32'h7);
        seq3(`CPMC_ADDR_POWER_KEY_FIRST, 32'h2, `CPMC_ADDR_POWER_MODE_CONTROL, 32'h7,
             `CPMC_ADDR_POWER_KEY_SECOND, 32'hF4);
        seq3(`CPMC_ADDR_POWER_KEY_FIRST, 32'h1, `CPMC_ADDR_POWER_MODE_CONTROL, 32'h7,
             `CPMC_ADDR_LOOP_KEY_SECOND, 32'h55);
        seq3(`CPMC_ADDR_POWER_KEY_FIRST, 32'h1, `CPMC_ADDR_POWER_MODE_CONTROL, 32'h7,
             `CPMC_ADDR_POWER_KEY_SECOND, 32'hF5);
        seq3(`CPMC_ADDR_LOOP_KEY_FIRST, 32'hAA, `CPMC_ADDR_POWER_MODE_CONTROL, 32'h7,
             `CPMC_ADDR_POWER_KEY_SECOND, 32'hF4);
        check_val({29'h0, core_clock_divider}, 32'h00000003, "divider after refused writes");
        $display("test bad keys done");
    endtask

    task automatic test_lock_loss();
        int cnt;
        loop_lock_pin <= 1'b0;
        wait_cyc(6);
        cnt = 0;
        repeat (32) begin
            @(posedge pclk);
            if (core_clock_enable === 1'b1) cnt++;
        end
        check_val(32'(cnt), 32'h00000000, "core clock while unlocked");
        check_flag(loop_irq, 1'b0, "loop interrupt before relock");
        loop_lock_pin <= 1'b1;
        wait_cyc(6);
        check_flag(loop_irq, 1'b1, "loop interrupt after relock");
        loop_irq_ack <= 1'b1;
        @(posedge pclk);
        loop_irq_ack <= 1'b0;
        wait_cyc(3);
        check_flag(loop_irq, 1'b0, "loop interrupt after ack");
        $display("test lock loss done");
    endtask

    task automatic mode_case(input logic [2:0] code, input logic [3:0] pw, input int blk, input int wak);
        key_write(1'b0, {1'b0, code, 4'h3});
        check_val({29'h0, operating_mode_field}, {29'h0, code}, "mode entered");
        check_val({28'h0, core_powered, peripherals_powered, loop_powered, timers_powered},
                  {28'h0, pw}, "power pattern");
        if (blk >= 0) begin
            set_src(blk, 1'b1);
            wait_cyc(8);
            check_val({29'h0, operating_mode_field}, {29'h0, code}, "mode kept on other source");
            set_src(blk, 1'b0);
            @(posedge pclk);
        end
        set_src(wak, 1'b1);
        wait_cyc(8);
        check_val({29'h0, operating_mode_field}, 32'h00000000, "woken to active");
        set_src(wak, 1'b0);
        wait_cyc(2);
    endtask

    task automatic test_modes();
        mode_case(cpmc_pkg::CPMC_OP_PAUSE, 4'h7, -1, 0);
        mode_case(cpmc_pkg::CPMC_OP_SLEEP, 4'h1, 0, 1);
        mode_case(cpmc_pkg::CPMC_OP_STOP, 4'h0, 1, 2);
        $display("test modes done");
    endtask

    task automatic test_source_switch();
        key_write(1'b1, 8'h03);
        rd_chk(`CPMC_ADDR_LOOP_CLOCK_CONTROL, 32'h00000003, 1'b0);
        check_flag(loop_reference_select, 1'b1, "reference held while active");
        check_val({30'h0, clock_source_mode}, 32'h00000001, "mode held while active");
        key_write(1'b0, 8'h23);
        check_val({29'h0, operating_mode_field}, {29'h0, cpmc_pkg::CPMC_OP_NAP}, "nap entered");
        check_flag(loop_reference_select, 1'b0, "crystal reference in nap");
        check_val({30'h0, clock_source_mode}, 32'h00000003, "external pin mode in nap");
        check_val({28'h0, core_powered, peripherals_powered, loop_powered, timers_powered},
                  32'h00000003, "nap power pattern");
        wake_timer <= 1'b1;
        wait_cyc(8);
        check_val({29'h0, operating_mode_field}, 32'h00000000, "woken from nap");
        check_flag(loop_reference_select, 1'b0, "new reference after wake");
        wake_timer <= 1'b0;
        $display("test source switch done");
    endtask

    // ==============================================
    // Main sequence
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        wait_cyc(4);
        test_reset();
        test_divider();
        test_bad_keys();
        test_lock_loss();
        test_modes();
        test_source_switch();
        wrap_up();
    end

endmodule

`default_nettype wire
